// ==== rtl/vcc_pkg.sv ====
// Package: register map, field layout and reset values of comparator control
package vcc_pkg;
    // Wishbone word offsets (byte addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_OUTCFG = 4'h8;
    // Control register field positions
    localparam int CTL_ENABLE = 7;
    localparam int CTL_STATE = 6;
    localparam int CTL_RISE = 5;
    localparam int CTL_FALL = 4;
    localparam int CTL_HYP_LO = 2;
    localparam int CTL_HYN_LO = 0;
    // Mode register field positions
    localparam int MD_RISE_IE = 5;
    localparam int MD_FALL_IE = 4;
    localparam int MD_RESP_LO = 0;
    // Output config register field positions
    localparam int OC_SYNC_PIN = 0;
    localparam int OC_RAW_PIN = 1;
    localparam int OC_RST_EN = 2;
    // Reset values
    localparam logic [1:0] HYST_RESET = 2'h0;
    localparam logic [1:0] RESP_RESET = 2'h2;
    // Hysteresis encoding: off, 5 mV, 10 mV, 20 mV
    localparam logic [1:0] HYST_OFF = 2'h0;
    localparam logic [1:0] HYST_5MV = 2'h1;
    localparam logic [1:0] HYST_10MV = 2'h2;
    localparam logic [1:0] HYST_20MV = 2'h3;
    // Analog trim bundle toward the comparator core
    typedef struct packed {
        logic power_on;
        logic [1:0] pos_hyst;
        logic [1:0] neg_hyst;
        logic [1:0] response;
    } vcc_analog_t;
endpackage

// ==== rtl/vcc_sync.sv ====
// Two-stage synchroniser for the comparator result
`timescale 1ns/100ps
module vcc_sync
(
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_async, // Asynchronous level
    output logic o_sync // Synchronised level
);
    logic stage1;

    // Only the second stage reads the first
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// ==== rtl/vcc_top.sv ====
// Comparator control: Wishbone registers, flags, outputs and reset request
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module vcc_top
(
    input wire logic I_CLK, // System clock, 250 MHz
    input wire logic I_RST_N, // Synchronous reset, active low
    input wire logic [3:0] I_WB_ADR, // Wishbone byte address
    input wire logic [31:0] I_WB_DAT, // Wishbone write data
    input wire logic [3:0] I_WB_SEL, // Wishbone byte selects
    input wire logic I_WB_WE, // Wishbone write enable
    input wire logic I_WB_CYC, // Wishbone cycle
    input wire logic I_WB_STB, // Wishbone strobe
    output logic [31:0] O_WB_DAT, // Wishbone read data
    output logic O_WB_ACK, // Wishbone acknowledge
    input wire logic I_CMP_RESULT, // Analog comparator decision, async
    output vcc_pkg::vcc_analog_t O_ANALOG, // Power and trim to the core
    output logic O_SYNC_PIN, // Latched output toward a pin
    output logic O_RAW_PIN, // Raw output toward a pin, no clock
    output logic O_IRQ, // Comparator interrupt request
    output logic O_RST_REQ // Reset request to the reset controller
);
    // Register fields and flags
    logic cmp_enable;
    logic cmp_rise_flag;
    logic cmp_fall_flag;
    logic cmp_rise_irq_en;
    logic cmp_fall_irq_en;
    logic [1:0] cmp_pos_hyst_sel;
    logic [1:0] cmp_neg_hyst_sel;
    logic [1:0] cmp_response_sel;
    logic route_sync;
    logic route_raw;
    logic reset_src_en;

    // Result path and edge detect
    logic cmp_sync_out;
    logic cmp_result_state;
    logic sync_prev;
    logic rise_evt;
    logic fall_evt;

    // Bus decode and read-back
    logic access;
    logic wr_ctl;
    logic wr_md;
    logic wr_oc;
    logic [31:0] next_rdata;
    logic wr_any;
    logic [1:0] edge_evt;
    logic [7:0] ctl_word;
    logic [7:0] md_word;
    logic [7:0] oc_word;

    // Result is resynchronised before anything samples it
    vcc_sync u_sync
    (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_async(I_CMP_RESULT),
        .o_sync(cmp_sync_out)
    );

    // Gated off when disabled, so a dead core reads and drives low
    // Trade-off: disabling while high flags one fall for software
    assign cmp_result_state = cmp_sync_out & cmp_enable;

    // Single-cycle ack; low-byte select guards every 8-bit register
    assign access = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    assign wr_any = access & I_WB_WE & I_WB_SEL[0];

    // One write strobe per register; unmapped writes fall through
    always_comb
    begin
        wr_ctl = 1'b0;
        wr_md = 1'b0;
        wr_oc = 1'b0;
        unique case (I_WB_ADR)
            vcc_pkg::ADDR_CONTROL:
                wr_ctl = wr_any;
            vcc_pkg::ADDR_MODE:
                wr_md = wr_any;
            vcc_pkg::ADDR_OUTCFG:
                wr_oc = wr_any;
            default:
                wr_ctl = 1'b0; // Unmapped place takes no write
        endcase
    end

    // Acknowledge one cycle after request, drop the cycle after
    // No wait state; a held strobe is taken every other cycle
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_WB_ACK <= 1'b0;
        else
            O_WB_ACK <= access;
    end

    // Enable and hysteresis in the control register
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            cmp_enable <= 1'b0;
            cmp_pos_hyst_sel <= vcc_pkg::HYST_RESET;
            cmp_neg_hyst_sel <= vcc_pkg::HYST_RESET;
        end
        else if (wr_ctl)
        begin
            cmp_enable <= I_WB_DAT[vcc_pkg::CTL_ENABLE];
            cmp_pos_hyst_sel <= I_WB_DAT[vcc_pkg::CTL_HYP_LO +: 2];
            cmp_neg_hyst_sel <= I_WB_DAT[vcc_pkg::CTL_HYN_LO +: 2];
        end
    end

    // Interrupt enables and response mode
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            cmp_rise_irq_en <= 1'b0;
            cmp_fall_irq_en <= 1'b0;
            cmp_response_sel <= vcc_pkg::RESP_RESET;
        end
        else if (wr_md)
        begin
            cmp_rise_irq_en <= I_WB_DAT[vcc_pkg::MD_RISE_IE];
            cmp_fall_irq_en <= I_WB_DAT[vcc_pkg::MD_FALL_IE];
            cmp_response_sel <= I_WB_DAT[vcc_pkg::MD_RESP_LO +: 2];
        end
    end

    // Pin routing and reset-source selection
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            route_sync <= 1'b0;
            route_raw <= 1'b0;
            reset_src_en <= 1'b0;
        end
        else if (wr_oc)
        begin
            route_sync <= I_WB_DAT[vcc_pkg::OC_SYNC_PIN];
            route_raw <= I_WB_DAT[vcc_pkg::OC_RAW_PIN];
            reset_src_en <= I_WB_DAT[vcc_pkg::OC_RST_EN];
        end
    end

    // Edge detect on the synchronised, enable-gated result
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            sync_prev <= 1'b0;
        else
            sync_prev <= cmp_result_state;
    end
    assign rise_evt = cmp_result_state & ~sync_prev;
    assign fall_evt = ~cmp_result_state & sync_prev;

    // Per-direction events: index 0 falls, index 1 rises
    assign edge_evt = {rise_evt, fall_evt};

    // Sticky flags; a same-cycle event beats the software clear
    for (genvar g = 0; g < $bits(edge_evt); g++)
    begin : g_edge
        localparam int FLAG_BIT = (g == 1) ? vcc_pkg::CTL_RISE
            : vcc_pkg::CTL_FALL;
        logic flag;

        always_ff @(posedge I_CLK)
        begin
            if (!I_RST_N)
                flag <= 1'b0;
            else if (edge_evt[g])
                flag <= 1'b1;
            else if (wr_ctl)
                flag <= I_WB_DAT[FLAG_BIT];
        end
    end
    // Flags leave the loop under their register names
    assign cmp_fall_flag = g_edge[0].flag;
    assign cmp_rise_flag = g_edge[1].flag;

    // Control read-back word; unused bits read as zero
    always_comb
    begin
        ctl_word = 8'h00;
        ctl_word[vcc_pkg::CTL_ENABLE] = cmp_enable;
        ctl_word[vcc_pkg::CTL_STATE] = cmp_result_state;
        ctl_word[vcc_pkg::CTL_RISE] = cmp_rise_flag;
        ctl_word[vcc_pkg::CTL_FALL] = cmp_fall_flag;
        ctl_word[vcc_pkg::CTL_HYP_LO +: 2] = cmp_pos_hyst_sel;
        ctl_word[vcc_pkg::CTL_HYN_LO +: 2] = cmp_neg_hyst_sel;
    end

    // Mode read-back word
    always_comb
    begin
        md_word = 8'h00;
        md_word[vcc_pkg::MD_RISE_IE] = cmp_rise_irq_en;
        md_word[vcc_pkg::MD_FALL_IE] = cmp_fall_irq_en;
        md_word[vcc_pkg::MD_RESP_LO +: 2] = cmp_response_sel;
    end

    // Output config read-back word
    always_comb
    begin
        oc_word = 8'h00;
        oc_word[vcc_pkg::OC_SYNC_PIN] = route_sync;
        oc_word[vcc_pkg::OC_RAW_PIN] = route_raw;
        oc_word[vcc_pkg::OC_RST_EN] = reset_src_en;
    end

    // Read mux; reads have no side effect on any flag
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (I_WB_ADR)
            vcc_pkg::ADDR_CONTROL:
                next_rdata = {24'h00_0000, ctl_word};
            vcc_pkg::ADDR_MODE:
                next_rdata = {24'h00_0000, md_word};
            vcc_pkg::ADDR_OUTCFG:
                next_rdata = {24'h00_0000, oc_word};
            default:
                next_rdata = 32'h0000_0000; // Unmapped reads as zero
        endcase
    end

    // Registered read data
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_WB_DAT <= 32'h0000_0000;
        else if (access && !I_WB_WE)
            O_WB_DAT <= next_rdata;
    end

    // Trim bundle; hysteresis codes pass straight to the core
    // The core decodes the codes itself; no remap is done here
    always_comb
    begin
        O_ANALOG.power_on = cmp_enable;
        O_ANALOG.pos_hyst = cmp_pos_hyst_sel;
        O_ANALOG.neg_hyst = cmp_neg_hyst_sel;
        O_ANALOG.response = cmp_response_sel;
    end

    // Latched pin output, low when disabled or not routed
    // Registered so the pin never shows a decode glitch
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_SYNC_PIN <= 1'b0;
        else
            O_SYNC_PIN <= cmp_result_state & route_sync;
    end

    // Raw path bypasses all clocking so it works in stop mode
    // Limitation: core chatter reaches this pin unfiltered
    assign O_RAW_PIN = I_CMP_RESULT & cmp_enable & route_raw;

    // Each direction masked on its own, ORed into one request
    assign O_IRQ = (cmp_rise_flag & cmp_rise_irq_en)
        | (cmp_fall_flag & cmp_fall_irq_en);

    // Reset request follows the inverted synchronised result when selected and enabled
    // Registered so a runt on the core cannot fire a reset
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_RST_REQ <= 1'b0;
        else
            O_RST_REQ <= reset_src_en & cmp_enable & ~cmp_sync_out;
    end
endmodule

// ==== test/test_voltage_comparator_control.sv ====
// Testbench: registers, sticky flags, masking and pin gating
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); \
    end end
module test_voltage_comparator_control;
    logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic above = 1'b0, res, ack, syncp, rawp, irq, rstq;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v, h;
    vcc_pkg::vcc_analog_t ana;
    int mismatches = 0, total_checks = 0, seed = 32'hA695;
    // 250 MHz system clock
    always #2 clk = ~clk;
    vcc_top u_vcc_top (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_ADR(adr),
        .I_WB_DAT(dat), .I_WB_SEL(sel), .I_WB_WE(we), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_CMP_RESULT(res),
        .O_ANALOG(ana), .O_SYNC_PIN(syncp), .O_RAW_PIN(rawp), .O_IRQ(irq),
        .O_RST_REQ(rstq));
    vcc_cmp_model u_vcc_cmp_model (.i_above(above), .o_result(res));
    task print_verdict;
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Classic cycle, held until ack is sampled, bounded wait
    task wb(input logic [3:0] a, input logic [7:0] d, input logic w,
        input logic [3:0] s);
        int n;
        @(posedge clk);
        {adr, dat, we, sel} <= {a, 24'h0, d, w, s};
        {cyc, stb} <= 2'h3;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            mismatches++;
            print_verdict;
        end
        else
            {cyc, stb} <= 2'h0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb(a, 8'h00, 1'b0, 4'hF);
    endtask
    task drive(input logic v);
        above <= v;
        repeat (10) @(posedge clk);
    endtask
    // Read data against the oldest note, at the ack edge
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
        begin
            exp_v = exp_q.pop_front();
            `CHK("read data", {24'h0, exp_v}, rdat)
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, unmapped place, write without low select
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h02);
        rd(4'h8, 8'h00);
        rd(4'hC, 8'h00);
        wb(4'h0, 8'h80, 1'b1, 4'hE);
        rd(4'h0, 8'h00);
        // Every hysteresis and response code, negative side random
        for (int i = 0; i < 4; i++)
        begin
            h = {4'h8, i[1:0], 2'($random(seed))};
            wb(4'h0, h, 1'b1, 4'h1);
            wb(4'h4, {6'h0, i[1:0]}, 1'b1, 4'h1);
            rd(4'h0, h);
            rd(4'h4, {6'h0, i[1:0]});
        end
        // Both pins routed, reset source on, both edges unmasked
        wb(4'h8, 8'h07, 1'b1, 4'h1);
        rd(4'h8, 8'h07);
        wb(4'h4, 8'h33, 1'b1, 4'h1);
        drive(1'b1);
        `CHK("irq", 1'b1, irq)
        `CHK("pins", 3'h6, {syncp, rawp, rstq})
        rd(4'h0, h | 8'h60);
        drive(1'b0);
        `CHK("reset request", 1'b1, rstq)
        rd(4'h0, h | 8'h30);
        rd(4'h0, h | 8'h30);
        // Software clears both flags, then only falling edges interrupt
        wb(4'h0, h, 1'b1, 4'h1);
        `CHK("irq", 1'b0, irq)
        wb(4'h4, 8'h13, 1'b1, 4'h1);
        drive(1'b1);
        `CHK("irq", 1'b0, irq)
        drive(1'b0);
        `CHK("irq", 1'b1, irq)
        // Clear lands on the rise event edge; the set must win
        above <= 1'b1;
        @(posedge clk);
        wb(4'h0, h, 1'b1, 4'h1);
        rd(4'h0, h | 8'h60);
        `CHK("irq", 1'b0, irq)
        // Disable while the result is high
        drive(1'b1);
        wb(4'h0, 8'h00, 1'b1, 4'h1);
        repeat (4) @(posedge clk);
        `CHK("off", 3'h0, {syncp, rawp, ana.power_on})
        rd(4'h0, 8'h10);
        print_verdict;
    end
endmodule

// ==== test/vcc_cmp_model.sv ====
// Analog core model: decision follows the inputs off the clock edge
`timescale 1ns/100ps
module vcc_cmp_model
(
    input wire logic i_above, // Plus input above minus input
    output logic o_result // Comparator decision
);
    // Lag lands between edges, so the synchroniser sees an async change
    initial o_result = 1'b0;
    always @(i_above)
        o_result <= #3 i_above;
endmodule

// ==== test/vcc_top_assertions.sv ====
// Checker for bus timing, register effects and pin gating
`timescale 1ns/100ps
module vcc_top_assertions
(
    input wire logic I_CLK, // Clock
    input wire logic I_RST_N, // Reset
    input wire logic [3:0] I_WB_ADR, // Address
    input wire logic [31:0] I_WB_DAT, // Write data
    input wire logic [3:0] I_WB_SEL, // Selects
    input wire logic I_WB_WE, // Write
    input wire logic I_WB_CYC, // Cycle
    input wire logic I_WB_STB, // Strobe
    input wire logic O_WB_ACK, // Ack
    input wire logic I_CMP_RESULT, // Result
    input wire vcc_pkg::vcc_analog_t O_ANALOG, // Core controls
    input wire logic O_SYNC_PIN, // Latched pin
    input wire logic O_RAW_PIN, // Raw pin
    input wire logic O_RST_REQ // Reset request
);
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    logic wr_ct, wr_md;
    // Accepted low-byte writes, visible in their ack cycle
    assign wr_ct = O_WB_ACK && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 4'h0;
    assign wr_md = O_WB_ACK && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 4'h4;
    property p_ack;
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("Ack late or long");
    property p_raw;
        O_RAW_PIN |-> I_CMP_RESULT && O_ANALOG.power_on;
    endproperty
    a_raw: assert property (p_raw) else $error("Raw pin high");
    property p_sync;
        O_SYNC_PIN |-> $past(O_ANALOG.power_on);
    endproperty
    a_sync: assert property (p_sync) else $error("Sync pin high");
    property p_rreq;
        O_RST_REQ |-> $past(O_ANALOG.power_on);
    endproperty
    a_rreq: assert property (p_rreq) else $error("Reset request");
    property p_rst;
        $rose(I_RST_N) |-> O_ANALOG == 7'h02;
    endproperty
    a_rst: assert property (p_rst) else $error("Reset values");
    property p_en;
        wr_ct |-> O_ANALOG.power_on == I_WB_DAT[7];
    endproperty
    a_en: assert property (p_en) else $error("Enable write");
    property p_hyst;
        wr_ct |-> {O_ANALOG.pos_hyst, O_ANALOG.neg_hyst} == I_WB_DAT[3:0];
    endproperty
    a_hyst: assert property (p_hyst) else $error("Hyst");
    property p_resp;
        wr_md |-> O_ANALOG.response == I_WB_DAT[1:0];
    endproperty
    a_resp: assert property (p_resp) else $error("Response write");
    c_pins: cover property (O_RAW_PIN && O_SYNC_PIN);
    c_rreq: cover property (O_RST_REQ);
    c_wr: cover property (wr_md);
endmodule
bind vcc_top vcc_top_assertions u_vcc_top_assertions (.I_CLK, .I_RST_N,
    .I_WB_ADR, .I_WB_DAT, .I_WB_SEL, .I_WB_WE, .I_WB_CYC, .I_WB_STB,
    .O_WB_ACK, .I_CMP_RESULT, .O_ANALOG, .O_SYNC_PIN, .O_RAW_PIN, .O_RST_REQ);
